/* common/slf_pkg.sv */
package slf_pkg;
  // Clock and control-rate timing
  localparam int CLK_HZ = 100_000_000;
  localparam int SUPPLY_HZ_DEF = 50;
  localparam int TICKS_PER_CYCLE = 6;
  localparam int TICK_CYCLES_DEF = CLK_HZ / (TICKS_PER_CYCLE * SUPPLY_HZ_DEF);

  // Speed-path widths and scaling
  localparam int SPD_W = 12;
  localparam int SPD_LIM = 1000;
  localparam int RPM_LIM = 1999;
  localparam int FULL_SCALE = 1000;
  localparam int ENC_W = 16;
  localparam int ENC_SHIFT = 10;
  localparam int IR_SHIFT = 11;
  localparam int FILT_SHIFT = 8;
  localparam int OFFSET_CENTER = 128;
  localparam int OFFSET_SHIFT = 4;

  // Register byte offsets
  localparam logic [7:0] ADDR_AV_SEL = 8'h00;
  localparam logic [7:0] ADDR_ENC_SCALE = 8'h04;
  localparam logic [7:0] ADDR_MAX_AV = 8'h08;
  localparam logic [7:0] ADDR_MAX_SPD = 8'h0C;
  localparam logic [7:0] ADDR_IR_COMP = 8'h10;
  localparam logic [7:0] ADDR_HREF = 8'h14;
  localparam logic [7:0] ADDR_HREF_SEL = 8'h18;
  localparam logic [7:0] ADDR_DROOP = 8'h1C;
  localparam logic [7:0] ADDR_RAMP_SEL = 8'h20;
  localparam logic [7:0] ADDR_FINE_OFS = 8'h24;
  localparam logic [7:0] ADDR_ZERO_THR = 8'h28;
  localparam logic [7:0] ADDR_DSRC = 8'h2C;
  localparam logic [7:0] ADDR_FILT = 8'h30;
  localparam logic [7:0] ADDR_TACHO = 8'h34;
  localparam logic [7:0] ADDR_DIG_SEL = 8'h38;
  localparam logic [7:0] ADDR_DEMAND = 8'h40;
  localparam logic [7:0] ADDR_FB = 8'h44;
  localparam logic [7:0] ADDR_RPM = 8'h48;
  localparam logic [7:0] ADDR_ERR = 8'h4C;
  localparam logic [7:0] ADDR_COMP = 8'h50;
  localparam logic [7:0] ADDR_STATUS = 8'h54;

  // Reset values
  localparam logic RST_AV_SEL = 1'h0;
  localparam logic [10:0] RST_ENC_SCALE = 11'h1A3;
  localparam logic [9:0] RST_MAX_AV = 10'h258;
  localparam logic [10:0] RST_MAX_SPD = 11'h6D6;
  localparam logic [7:0] RST_IR_COMP = 8'h00;
  localparam logic [SPD_W-1:0] RST_HREF = 12'h000;
  localparam logic RST_HREF_SEL = 1'h0;
  localparam logic RST_DROOP = 1'h0;
  localparam logic RST_RAMP_SEL = 1'h1;
  localparam logic [7:0] RST_FINE_OFS = 8'h80;
  localparam logic [7:0] RST_ZERO_THR = 8'h10;
  localparam logic [7:0] RST_FILT = 8'h80;
  localparam logic RST_DIG_SEL = 1'h0;

  typedef enum logic [1:0] {
    DSRC_ERR = 2'b01,
    DSRC_DEM = 2'b10,
    DSRC_FB = 2'b11
  } slf_dsrc_t;
  localparam slf_dsrc_t RST_DSRC = DSRC_ERR;
endpackage

/* src/slf_sat.sv */
`timescale 1ns/1ns
module slf_sat
  import slf_pkg::*;
#(
  parameter int IN_W = 24,
  parameter int LIM = 1000
)
(
  input wire logic signed [IN_W-1:0] i_val, // Wide signed value
  output logic signed [SPD_W-1:0] o_val // Value clamped to +/-LIM
);
  localparam logic signed [IN_W-1:0] HI = IN_W'(LIM);
  localparam logic signed [IN_W-1:0] LO = -IN_W'(LIM);

  generate
    if (IN_W < SPD_W || LIM >= 2 ** (SPD_W - 1))
    begin : g_chk
      $error("slf_sat: width or limit out of range");
    end
  endgenerate

  always_comb
  begin
    if (i_val > HI)
      o_val = SPD_W'(LIM);
    else if (i_val < LO)
      o_val = -SPD_W'(LIM);
    else
      o_val = i_val[SPD_W-1:0];
  end
endmodule

/* src/slf_lpf.sv */
`timescale 1ns/1ns
module slf_lpf
  import slf_pkg::*;
(
  input wire logic i_sys_clk, // System clock
  input wire logic i_reset, // Asynchronous reset
  input wire logic i_tick, // Control-rate enable
  input wire logic signed [SPD_W-1:0] i_x, // Unfiltered error
  input wire logic [7:0] i_coef, // Filter setting
  output logic signed [SPD_W-1:0] o_y // Filtered error
);
  typedef struct packed {
    logic signed [SPD_W-1:0] y;
  } slf_lpf_st_t;

  slf_lpf_st_t r_reg;
  slf_lpf_st_t r_next;
  logic signed [SPD_W:0] diff;
  logic signed [SPD_W+9:0] step;

  // Each tick moves the output by coef/256 of the remaining gap
  assign diff = (SPD_W+1)'(i_x) - (SPD_W+1)'(r_reg.y);
  assign step = ((SPD_W+10)'(diff) * $signed({2'b00, i_coef})) >>> FILT_SHIFT;

  always_comb
  begin
    r_next = r_reg;
    if (i_tick)
      r_next.y = r_reg.y + step[SPD_W-1:0];
  end

  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign o_y = r_reg.y;
endmodule

/* src/slf_speed_front.sv */
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ns
module slf_speed_front
  import slf_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
  input wire logic i_sys_clk, // 100 MHz clock
  input wire logic i_reset, // Asynchronous reset, active high
  input wire logic i_psel, // APB select
  input wire logic i_penable, // APB enable
  input wire logic i_pwrite, // APB direction
  input wire logic [7:0] i_paddr, // APB byte address
  input wire logic [31:0] i_pwdata, // APB write data
  output logic [31:0] o_prdata, // APB read data
  output logic o_pready, // APB ready
  output logic o_pslverr, // APB error
  input wire logic signed [ENC_W-1:0] i_enc_count, // Encoder counts per tick
  input wire logic signed [SPD_W-1:0] i_tacho, // Tacho measurement
  input wire logic signed [SPD_W-1:0] i_arm_volts, // Armature volts
  input wire logic signed [SPD_W-1:0] i_ramp_out, // Ramp output
  input wire logic signed [SPD_W-1:0] i_err_integral, // Speed error integral
  input wire logic i_ref_on, // Reference on flag
  output logic signed [SPD_W-1:0] o_final_demand, // Final speed demand
  output logic signed [SPD_W-1:0] o_speed_fb, // Speed feedback
  output logic signed [SPD_W-1:0] o_speed_rpm, // Feedback in rpm
  output logic signed [SPD_W-1:0] o_speed_err, // Filtered speed error
  output logic signed [SPD_W-1:0] o_ir_comp, // Compensation output
  output logic signed [SPD_W-1:0] o_deriv_in, // Derivative source value
  output logic o_zero_speed, // Zero speed indication
  output logic o_volt_clamp, // Armature voltage clamp
  output logic o_ctrl_tick // Control-rate pulse
);
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  generate
    if (TICK_CYCLES < 1)
    begin : g_chk
      $error("slf_speed_front: TICK_CYCLES must be at least 1");
    end
  endgenerate

  typedef struct packed {
    logic [TICK_W-1:0] div;
    logic tick, dig_sel, av_sel;
    logic [10:0] enc_scale;
    logic [9:0] max_av;
    logic [10:0] max_spd;
    logic [7:0] ir_fac;
    logic signed [SPD_W-1:0] href;
    logic href_sel, droop, ramp_sel;
    logic [7:0] fine_ofs;
    logic [7:0] zero_thr;
    slf_dsrc_t dsrc;
    logic [7:0] filt;
    logic pready, pslverr;
    logic [31:0] prdata;
    logic signed [SPD_W-1:0] demand, fb, rpm, err_raw, comp, deriv, tacho;
    logic zero, clamp;
  } slf_st_t;

  slf_st_t r_reg;
  slf_st_t r_next;

  logic signed [27:0] enc_wide;
  logic signed [22:0] av_wide;
  logic signed [20:0] comp_wide;
  logic signed [23:0] avfb_wide, rpm_wide;
  logic signed [14:0] dem_wide, err_wide;
  logic signed [9:0] ofs_val;
  logic signed [SPD_W-1:0] enc_sat, comp_sat, avfb_sat, tacho_sat, rpm_sat, dem_sat;
  logic signed [SPD_W-1:0] err_sat, fb_sel, err_filt, fb_abs, av_abs;
  logic use_av, wr_en;

  assign use_av = !r_reg.dig_sel && r_reg.av_sel;

  assign enc_wide = (28'(i_enc_count) * $signed({17'h00000, r_reg.enc_scale}))
    >>> ENC_SHIFT;
  // A zero maximum gives no armature feedback rather than a divide fault
  assign av_wide = (r_reg.max_av == 10'h000) ? 23'sh000000 :
    (23'(i_arm_volts) * 23'(FULL_SCALE)) / $signed({13'h0000, r_reg.max_av});
  assign comp_wide = (21'(i_err_integral) * $signed({13'h0000, r_reg.ir_fac}))
    >>> IR_SHIFT;
  assign avfb_wide = r_reg.droop ? 24'(av_wide) - 24'(comp_sat) :
    24'(av_wide) + 24'(comp_sat);
  assign rpm_wide = (24'(fb_sel) * $signed({13'h0000, r_reg.max_spd})) /
    24'(FULL_SCALE);
  assign ofs_val = ($signed({2'b00, r_reg.fine_ofs}) - 10'sd128) >>> OFFSET_SHIFT;
  assign dem_wide = (r_reg.ramp_sel ? 15'(i_ramp_out) : 15'sd0)
    + ((r_reg.href_sel && i_ref_on) ? 15'(r_reg.href) : 15'sd0)
    + 15'(ofs_val);
  assign err_wide = 15'(dem_sat) - 15'(fb_sel);

  slf_sat #(.IN_W(28), .LIM(SPD_LIM)) u_sat_enc (
    .i_val(enc_wide),
    .o_val(enc_sat)
  );
  slf_sat #(.IN_W(21), .LIM(SPD_LIM)) u_sat_comp (
    .i_val(comp_wide),
    .o_val(comp_sat)
  );
  slf_sat #(.IN_W(24), .LIM(SPD_LIM)) u_sat_avfb (
    .i_val(avfb_wide),
    .o_val(avfb_sat)
  );
  slf_sat #(.IN_W(SPD_W), .LIM(SPD_LIM)) u_sat_tacho (
    .i_val(i_tacho),
    .o_val(tacho_sat)
  );
  slf_sat #(.IN_W(24), .LIM(RPM_LIM)) u_sat_rpm (
    .i_val(rpm_wide),
    .o_val(rpm_sat)
  );
  slf_sat #(.IN_W(15), .LIM(SPD_LIM)) u_sat_dem (
    .i_val(dem_wide),
    .o_val(dem_sat)
  );
  slf_sat #(.IN_W(15), .LIM(SPD_LIM)) u_sat_err (
    .i_val(err_wide),
    .o_val(err_sat)
  );

  slf_lpf u_lpf (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_tick(r_reg.tick),
    .i_x(r_reg.err_raw),
    .i_coef(r_reg.filt),
    .o_y(err_filt)
  );

  assign fb_sel = r_reg.dig_sel ? enc_sat :
    (r_reg.av_sel ? avfb_sat : tacho_sat);
  assign fb_abs = fb_sel[SPD_W-1] ? -fb_sel : fb_sel;
  assign av_abs = i_arm_volts[SPD_W-1] ? -i_arm_volts : i_arm_volts;
  assign wr_en = i_psel && i_penable && r_reg.pready && i_pwrite && !r_reg.pslverr;

  always_comb
  begin
    r_next = r_reg;
    r_next.tick = 1'b0;
    r_next.pready = 1'b0;
    r_next.pslverr = 1'b0;
    if (r_reg.div == TICK_W'(TICK_CYCLES - 1))
    begin
      r_next.div = '0;
      r_next.tick = 1'b1;
    end
    else
      r_next.div = r_reg.div + 1'b1;

    // Speed path updates once per control tick
    if (r_reg.tick)
    begin
      r_next.fb = fb_sel;
      r_next.comp = use_av ? comp_sat : 12'sh000;
      r_next.demand = dem_sat;
      r_next.err_raw = err_sat;
      r_next.tacho = tacho_sat;
      r_next.rpm = rpm_sat;
      r_next.clamp = !use_av && ({1'b0, av_abs} > {3'b000, r_reg.max_av});
      r_next.zero = fb_abs < $signed({4'h0, r_reg.zero_thr});
      case (r_reg.dsrc)
        DSRC_DEM: r_next.deriv = dem_sat;
        DSRC_FB: r_next.deriv = fb_sel;
        default: r_next.deriv = err_filt;
      endcase
    end

    // Setup phase: decode and answer in the following access cycle
    if (i_psel && !i_penable)
    begin
      r_next.pready = 1'b1;
      r_next.prdata = 32'h00000000;
      if (i_paddr == ADDR_AV_SEL)
        r_next.prdata[0] = r_reg.av_sel;
      else if (i_paddr == ADDR_DIG_SEL)
        r_next.prdata[0] = r_reg.dig_sel;
      else if (i_paddr == ADDR_ENC_SCALE)
        r_next.prdata[10:0] = r_reg.enc_scale;
      else if (i_paddr == ADDR_MAX_AV)
        r_next.prdata[9:0] = r_reg.max_av;
      else if (i_paddr == ADDR_MAX_SPD)
        r_next.prdata[10:0] = r_reg.max_spd;
      else if (i_paddr == ADDR_IR_COMP)
        r_next.prdata[7:0] = r_reg.ir_fac;
      else if (i_paddr == ADDR_HREF)
        r_next.prdata[SPD_W-1:0] = r_reg.href;
      else if (i_paddr == ADDR_HREF_SEL)
        r_next.prdata[0] = r_reg.href_sel;
      else if (i_paddr == ADDR_DROOP)
        r_next.prdata[0] = r_reg.droop;
      else if (i_paddr == ADDR_RAMP_SEL)
        r_next.prdata[0] = r_reg.ramp_sel;
      else if (i_paddr == ADDR_FINE_OFS)
        r_next.prdata[7:0] = r_reg.fine_ofs;
      else if (i_paddr == ADDR_ZERO_THR)
        r_next.prdata[7:0] = r_reg.zero_thr;
      else if (i_paddr == ADDR_DSRC)
        r_next.prdata[1:0] = r_reg.dsrc;
      else if (i_paddr == ADDR_FILT)
        r_next.prdata[7:0] = r_reg.filt;
      else if (i_paddr == ADDR_TACHO)
        r_next.prdata[SPD_W-1:0] = r_reg.tacho;
      else if (i_paddr == ADDR_DEMAND)
        r_next.prdata[SPD_W-1:0] = r_reg.demand;
      else if (i_paddr == ADDR_FB)
        r_next.prdata[SPD_W-1:0] = r_reg.fb;
      else if (i_paddr == ADDR_RPM)
        r_next.prdata[SPD_W-1:0] = r_reg.rpm;
      else if (i_paddr == ADDR_ERR)
        r_next.prdata[SPD_W-1:0] = err_filt;
      else if (i_paddr == ADDR_COMP)
        r_next.prdata[SPD_W-1:0] = r_reg.comp;
      else if (i_paddr == ADDR_STATUS)
        r_next.prdata[1:0] = {r_reg.clamp, r_reg.zero};
      else
        r_next.pslverr = 1'b1;
    end

    // Writes land at the completing access edge; unmapped or read-only ignored
    if (wr_en)
    begin
      if (i_paddr == ADDR_AV_SEL)
        r_next.av_sel = i_pwdata[0];
      else if (i_paddr == ADDR_DIG_SEL)
        r_next.dig_sel = i_pwdata[0];
      else if (i_paddr == ADDR_ENC_SCALE)
        r_next.enc_scale = i_pwdata[10:0];
      else if (i_paddr == ADDR_MAX_AV)
        r_next.max_av = i_pwdata[9:0];
      else if (i_paddr == ADDR_MAX_SPD)
        r_next.max_spd = i_pwdata[10:0];
      else if (i_paddr == ADDR_IR_COMP)
        r_next.ir_fac = i_pwdata[7:0];
      else if (i_paddr == ADDR_HREF)
        r_next.href = i_pwdata[SPD_W-1:0];
      else if (i_paddr == ADDR_HREF_SEL)
        r_next.href_sel = i_pwdata[0];
      else if (i_paddr == ADDR_DROOP)
        r_next.droop = i_pwdata[0];
      else if (i_paddr == ADDR_RAMP_SEL)
        r_next.ramp_sel = i_pwdata[0];
      else if (i_paddr == ADDR_FINE_OFS)
        r_next.fine_ofs = i_pwdata[7:0];
      else if (i_paddr == ADDR_ZERO_THR)
        r_next.zero_thr = i_pwdata[7:0];
      else if (i_paddr == ADDR_DSRC)
        r_next.dsrc = (i_pwdata[1:0] == 2'b00) ? DSRC_ERR : slf_dsrc_t'(i_pwdata[1:0]);
      else if (i_paddr == ADDR_FILT)
        r_next.filt = i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      r_reg <= '0;
      r_reg.av_sel <= RST_AV_SEL;
      r_reg.dig_sel <= RST_DIG_SEL;
      r_reg.enc_scale <= RST_ENC_SCALE;
      r_reg.max_av <= RST_MAX_AV;
      r_reg.max_spd <= RST_MAX_SPD;
      r_reg.ir_fac <= RST_IR_COMP;
      r_reg.href <= RST_HREF;
      r_reg.href_sel <= RST_HREF_SEL;
      r_reg.droop <= RST_DROOP;
      r_reg.ramp_sel <= RST_RAMP_SEL;
      r_reg.fine_ofs <= RST_FINE_OFS;
      r_reg.zero_thr <= RST_ZERO_THR;
      r_reg.dsrc <= RST_DSRC;
      r_reg.filt <= RST_FILT;
    end
    else
      r_reg <= r_next;
  end

  assign o_prdata = r_reg.prdata;
  assign o_pready = r_reg.pready;
  assign o_pslverr = r_reg.pslverr;
  assign o_final_demand = r_reg.demand;
  assign o_speed_fb = r_reg.fb;
  assign o_speed_rpm = r_reg.rpm;
  assign o_speed_err = err_filt;
  assign o_ir_comp = r_reg.comp;
  assign o_deriv_in = r_reg.deriv;
  assign o_zero_speed = r_reg.zero;
  assign o_volt_clamp = r_reg.clamp;
  assign o_ctrl_tick = r_reg.tick;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);

  property p_tacho_sel;
    (r_reg.tick && !r_reg.dig_sel && !r_reg.av_sel) |=> (o_speed_fb == $past(tacho_sat));
  endproperty
  a_tacho_sel: assert property (p_tacho_sel) else $error("tacho feedback not selected");

  property p_enc_sel;
    (r_reg.tick && r_reg.dig_sel) |=> (o_speed_fb == $past(enc_sat));
  endproperty
  a_enc_sel: assert property (p_enc_sel) else $error("encoder feedback not selected");

  property p_clamp_off_av;
    (r_reg.tick && use_av) |=> !o_volt_clamp;
  endproperty
  a_clamp_off_av: assert property (p_clamp_off_av) else $error("clamp active under av feedback");

  property p_comp_only_av;
    (r_reg.tick && !use_av) |=> (o_ir_comp == 12'sh000);
  endproperty
  a_comp_only_av: assert property (p_comp_only_av) else $error("compensation outside av mode");

  property p_demand_plain;
    (r_reg.tick && !r_reg.ramp_sel && !r_reg.href_sel && r_reg.fine_ofs == 8'h80)
      |=> (o_final_demand == 12'sh000);
  endproperty
  a_demand_plain: assert property (p_demand_plain) else $error("demand not zero with no sources");

  property p_href_only;
    (r_reg.tick && !r_reg.ramp_sel && r_reg.href_sel && i_ref_on && r_reg.fine_ofs == 8'h80
      && r_reg.href <= 12'sd1000 && r_reg.href >= -12'sd1000)
      |=> (o_final_demand == $past(r_reg.href));
  endproperty
  a_href_only: assert property (p_href_only) else $error("hard reference not passed");
  property p_zero;
    r_reg.tick |=> (o_zero_speed == ((o_speed_fb < $signed({4'h0, $past(r_reg.zero_thr)}))
      && (o_speed_fb > -$signed({4'h0, $past(r_reg.zero_thr)}))));
  endproperty
  a_zero: assert property (p_zero) else $error("zero speed flag wrong");
  property p_deriv_fb;
    (r_reg.tick && r_reg.dsrc == DSRC_FB) |=> (o_deriv_in == o_speed_fb);
  endproperty
  a_deriv_fb: assert property (p_deriv_fb) else $error("derivative source not feedback");

  property p_bounds;
    (o_speed_fb <= 12'sd1000) && (o_speed_fb >= -12'sd1000)
      && (o_final_demand <= 12'sd1000) && (o_final_demand >= -12'sd1000);
  endproperty
  a_bounds: assert property (p_bounds) else $error("speed quantity beyond limit");

  property p_apb_ready;
    (i_psel && !i_penable) |=> o_pready ##1 !o_pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("apb ready timing wrong");
endmodule

/* tb/slf_sensor_model.sv */
`timescale 1ns/1ns
module slf_sensor_model
  import slf_pkg::*;
(
  input wire logic i_sys_clk, // System clock
  output logic signed [ENC_W-1:0] o_enc_count, // Encoder counts per tick
  output logic signed [SPD_W-1:0] o_tacho, // Tacho measurement
  output logic signed [SPD_W-1:0] o_arm_volts, // Armature volts
  output logic signed [SPD_W-1:0] o_ramp_out, // Ramp output
  output logic signed [SPD_W-1:0] o_err_integral // Speed error integral
);
  initial
  begin
    o_enc_count = '0;
    o_tacho = '0;
    o_arm_volts = '0;
    o_ramp_out = '0;
    o_err_integral = '0;
  end

  // New readings land right after a rising edge and then stand
  task automatic set_all(input int enc, input int tch, input int av, input int rmp, input int ig);
    @(posedge i_sys_clk);
    o_enc_count <= ENC_W'(enc);
    o_tacho <= SPD_W'(tch);
    o_arm_volts <= SPD_W'(av);
    o_ramp_out <= SPD_W'(rmp);
    o_err_integral <= SPD_W'(ig);
  endtask
endmodule

/* tb/tb.sv */
`timescale 1ns/1ns
module tb
  import slf_pkg::*;
;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic i_ref_on = 1'b0;
  logic [31:0] o_prdata;
  logic o_pready, o_pslverr, o_zero_speed, o_volt_clamp, o_ctrl_tick;
  logic signed [ENC_W-1:0] enc;
  logic signed [SPD_W-1:0] tch, av, rmp, ig;
  logic signed [SPD_W-1:0] o_final_demand, o_speed_fb, o_speed_rpm;
  logic signed [SPD_W-1:0] o_speed_err, o_ir_comp, o_deriv_in;
  int n_errors = 0;
  int checks = 0;
  logic [7:0] ra [14] = '{ADDR_AV_SEL, ADDR_ENC_SCALE, ADDR_MAX_AV, ADDR_MAX_SPD,
    ADDR_IR_COMP, ADDR_HREF, ADDR_HREF_SEL, ADDR_DROOP, ADDR_RAMP_SEL, ADDR_FINE_OFS,
    ADDR_ZERO_THR, ADDR_DSRC, ADDR_FILT, ADDR_DIG_SEL};
  logic [31:0] rv [14] = '{32'h0, 32'h1A3, 32'h258, 32'h6D6, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h1, 32'h80, 32'h10, 32'h1, 32'h80, 32'h0};

  slf_speed_front #(.TICK_CYCLES(8)) u_dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_enc_count(enc), .i_tacho(tch), .i_arm_volts(av), .i_ramp_out(rmp),
    .i_err_integral(ig), .i_ref_on(i_ref_on), .o_final_demand(o_final_demand),
    .o_speed_fb(o_speed_fb), .o_speed_rpm(o_speed_rpm), .o_speed_err(o_speed_err),
    .o_ir_comp(o_ir_comp), .o_deriv_in(o_deriv_in), .o_zero_speed(o_zero_speed),
    .o_volt_clamp(o_volt_clamp), .o_ctrl_tick(o_ctrl_tick));

  slf_sensor_model u_sens (.i_sys_clk(i_sys_clk), .o_enc_count(enc), .o_tacho(tch),
    .o_arm_volts(av), .o_ramp_out(rmp), .o_err_integral(ig));

  initial
  begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    int n;
    @(posedge i_sys_clk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge i_sys_clk);
      n++;
    end
    while (o_pready !== 1'b1 && n < 16);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (n >= 16)
      n_errors++;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, r, exp);
  endtask

  // Lets k control ticks pass so the speed path has taken the new inputs
  task automatic ticks(input int k);
    int n;
    repeat (k)
    begin
      n = 0;
      do
      begin
        @(posedge i_sys_clk);
        n++;
      end
      while (o_ctrl_tick !== 1'b1 && n < 64);
      if (n >= 64)
        n_errors++;
    end
    @(posedge i_sys_clk);
  endtask

  task automatic t_regs();
    logic [31:0] r;
    logic e;
    foreach (ra[i])
      rdc("reset value", ra[i], rv[i]);
    apb(1'b0, 8'h3C, 32'h0, r, e);
    chk("unmapped error", e, 1);
    chk("unmapped data", r, 0);
    apb(1'b1, ADDR_TACHO, 32'h55, r, e);
    chk("read-only write error", e, 0);
    wr(ADDR_ENC_SCALE, 32'h7CF);
    rdc("scale max", ADDR_ENC_SCALE, 32'h7CF);
    wr(ADDR_ENC_SCALE, 32'h1A3);
  endtask

  task automatic t_tacho();
    u_sens.set_all(0, 500, 0, 300, 0);
    ticks(3);
    chk("tacho fb", o_speed_fb, 500);
    chk("rpm", o_speed_rpm, 875);
    chk("demand", o_final_demand, 300);
    rdc("tacho readout", ADDR_TACHO, 32'h1F4);
    rdc("fb reg", ADDR_FB, 32'h1F4);
    rdc("rpm reg", ADDR_RPM, 32'h36B);
    wr(ADDR_DSRC, 32'h2);
    ticks(2);
    chk("deriv demand", o_deriv_in, 300);
    wr(ADDR_DSRC, 32'h3);
    ticks(2);
    chk("deriv fb", o_deriv_in, 500);
    wr(ADDR_DSRC, 32'h0);
    rdc("deriv zero", ADDR_DSRC, 32'h1);
  endtask

  task automatic t_encoder();
    wr(ADDR_DIG_SEL, 32'h1);
    u_sens.set_all(1000, 500, 0, 300, 0);
    ticks(3);
    chk("enc fb", o_speed_fb, 409);
    u_sens.set_all(-1000, 500, 0, 300, 0);
    ticks(3);
    chk("enc fb neg", o_speed_fb, -410);
    wr(ADDR_DIG_SEL, 32'h0);
  endtask

  task automatic t_armature();
    u_sens.set_all(0, 0, 300, 0, 400);
    wr(ADDR_AV_SEL, 32'h1);
    wr(ADDR_IR_COMP, 32'h80);
    ticks(3);
    chk("comp", o_ir_comp, 25);
    chk("av fb", o_speed_fb, 525);
    rdc("comp reg", ADDR_COMP, 32'h19);
    wr(ADDR_DROOP, 32'h1);
    u_sens.set_all(0, 0, 700, 0, 400);
    ticks(3);
    chk("droop fb", o_speed_fb, 1000);
    chk("no clamp", o_volt_clamp, 0);
    u_sens.set_all(0, 0, 300, 0, 400);
    ticks(3);
    chk("droop fb", o_speed_fb, 475);
    wr(ADDR_DROOP, 32'h0);
    wr(ADDR_IR_COMP, 32'h0);
    wr(ADDR_AV_SEL, 32'h0);
  endtask

  task automatic t_clamp();
    int v [3] = '{601, 600, -601};
    logic x [3] = '{1'b1, 1'b0, 1'b1};
    foreach (v[i])
    begin
      u_sens.set_all(0, 0, v[i], 0, 0);
      ticks(3);
      chk("clamp", o_volt_clamp, x[i]);
    end
    rdc("status reg", ADDR_STATUS, 32'h3);
  endtask

  task automatic t_demand();
    u_sens.set_all(0, 0, 0, 300, 0);
    wr(ADDR_HREF, 32'h64);
    wr(ADDR_HREF_SEL, 32'h1);
    i_ref_on <= 1'b1;
    ticks(3);
    chk("hard ref on", o_final_demand, 400);
    rdc("demand reg", ADDR_DEMAND, 32'h190);
    i_ref_on <= 1'b0;
    ticks(3);
    chk("hard ref off", o_final_demand, 300);
    i_ref_on <= 1'b1;
    wr(ADDR_RAMP_SEL, 32'h0);
    ticks(3);
    chk("ramp excluded", o_final_demand, 100);
    wr(ADDR_HREF_SEL, 32'h0);
    ticks(3);
    chk("no sources", o_final_demand, 0);
    wr(ADDR_HREF_SEL, 32'h1);
    wr(ADDR_RAMP_SEL, 32'h1);
    wr(ADDR_FINE_OFS, 32'h90);
    ticks(3);
    chk("offset up", o_final_demand, 401);
    wr(ADDR_FINE_OFS, 32'h00);
    ticks(3);
    chk("offset down", o_final_demand, 392);
    wr(ADDR_FINE_OFS, 32'h80);
    wr(ADDR_HREF, 32'h384);
    u_sens.set_all(0, 0, 0, 900, 0);
    ticks(3);
    chk("demand sat", o_final_demand, 1000);
    i_ref_on <= 1'b0;
    wr(ADDR_HREF_SEL, 32'h0);
  endtask

  task automatic t_zero();
    int v [3] = '{15, 16, -15};
    logic x [3] = '{1'b1, 1'b0, 1'b1};
    foreach (v[i])
    begin
      u_sens.set_all(0, v[i], 0, 0, 0);
      ticks(3);
      chk("zero speed", o_zero_speed, x[i]);
    end
  endtask

  task automatic t_filter();
    logic signed [SPD_W-1:0] y0;
    u_sens.set_all(0, 100, 0, 200, 0);
    ticks(40);
    wr(ADDR_FILT, 32'h0);
    ticks(2);
    y0 = o_speed_err;
    u_sens.set_all(0, 600, 0, 200, 0);
    ticks(4);
    chk("filter held", o_speed_err, y0);
    wr(ADDR_FILT, 32'h80);
    ticks(40);
    chk("filter settled", (o_speed_err >= -401 && o_speed_err <= -399), 1);
    chk("deriv error", o_deriv_in, -400);
    rdc("err reg", ADDR_ERR, 32'hE70);
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    #400000;
    n_errors++;
    wrap_up();
  end

  initial
  begin
    repeat (6) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    t_regs();
    t_tacho();
    t_encoder();
    t_armature();
    t_clamp();
    t_demand();
    t_zero();
    t_filter();
    wrap_up();
  end
endmodule
